// ==== nvram_link_pkg.sv ====
// Shared constants and types for both ends of the two-wire byte memory link
package nvram_link_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int LINK_PERIOD_NS = 1000;
  // Quarter of a serial clock period, rounded up to whole cycles
  localparam int QTR_CYCLES     = (LINK_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Array and address layout
  localparam int ADDR_W    = 11;
  localparam int MEM_DEPTH = 2048;
  localparam int TYPE_MSB  = 7;
  localparam int TYPE_LSB  = 4;
  localparam int UPPER_MSB = 3;
  localparam int UPPER_LSB = 1;
  localparam int RW_BIT    = 0;
  localparam int LOWER_MSB = 7;
  localparam logic [3:0]        TYPE_CODE_DEFAULT = 4'h6; // Arbitrary value
  localparam logic [ADDR_W-1:0] ADDR_STEP         = 11'h001;

  //////////////////////////////////////////////////////////////////////////////
  // Bit slot numbers within a byte
  localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
  localparam logic [3:0] ACK_SLOT       = 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // Master command codes
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_STOP  = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ  = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [2:0] {
    LS_DEVADDR = 3'b000,
    LS_LOWADDR = 3'b001,
    LS_WRDATA  = 3'b010,
    LS_RDDATA  = 3'b011,
    LS_IDLE    = 3'b100
  } link_state_type;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_START = 2'b01,
    HS_STOP  = 2'b10,
    HS_XFER  = 2'b11
  } host_state_type;

endpackage : nvram_link_pkg

// ==== nvram_link_if.sv ====
// Two-wire link between the master end and the memory slave end
interface nvram_link_if;
  logic scl;
  logic m_sda_oe;
  logic s_sda_oe;
  logic wp;
  logic sda;

  // Open-drain data wire with pull-up
  assign sda = !(m_sda_oe || s_sda_oe);

  modport master (output scl, output m_sda_oe, output wp, input sda);
  modport slave  (input scl, input sda, input wp, output s_sda_oe);
endinterface : nvram_link_if

// ==== bit_sync.sv ====
// Two-flop level synchroniser
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input  wire logic             clk_in,
  // Levels from another domain
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stage_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_in) begin
    meta_reg  <= async_in;
    stage_reg <= meta_reg;
  end

  assign sync_out = stage_reg;
endmodule : bit_sync

// ==== nvram_slave_end.sv ====
// Memory slave end: start/stop watch, serial byte engine and 2 K x 8 array
//
// Behaviour
// RQ1: Slave only; never drives the serial clock.
// RQ2: Sample on clock rise, change on fall.
// RQ3: Data output only pulls low or releases.
// RQ4: Master changes data only while clock low.
// RQ5: Data falling with clock high starts transaction.
// RQ6: Stop ends read or write, enters standby.
// RQ7: Byte writes finish instantly; never busy.
// RQ8: Everything moves in bytes plus acknowledge slot.
// RQ9: Receiver pulls data low on ninth clock.
// RQ10: Transmitter releases data on ninth clock.
// RQ11: Stop before acknowledge aborts to standby.
// RQ12: After not-acknowledge, release the data line.
// RQ13: Master then sends stop or new start.
// RQ14: Write protect high blocks all array writes.
// RQ15: Reads work whatever write protect says.
// RQ16: Array holds 2048 bytes, written bytewise.
// RQ17: Keep an 11-bit address buffer.
// RQ18: Upper three plus lower eight bits form address.
// RQ19: Current read joins new upper, buffered lower.
// RQ20: First byte: type, upper address, direction.
// RQ21: Wrong type code: no access, standby.
// RQ22: Address increments per byte, wraps to zero.
// RQ23: Write protect held steady start to stop.
// RQ24: Write byte committed within its acknowledge slot.
module nvram_slave_end #(
  parameter logic [3:0] TYPE_CODE = nvram_link_pkg::TYPE_CODE_DEFAULT, // Arbitrary value
  parameter int         MEM_DEPTH = nvram_link_pkg::MEM_DEPTH
) (
  // System clock and reset
  input  wire logic   mclk_in,
  input  wire logic   sys_rst_in,
  // Two-wire link
  nvram_link_if.slave link,
  // Status
  output logic        frame_active_out
);

  //////////////////////////////////////////////////////////////////////////////
  // System domain: start and stop detection

  logic [1:0] bus_s;
  logic       scl_d_reg;
  logic       scl_d_next;
  logic       sda_d_reg;
  logic       sda_d_next;
  logic       link_rst_reg;
  logic       link_rst_next;
  logic       frame_reg;
  logic       frame_next;
  logic       start_det;
  logic       stop_det;

  bit_sync #(
    .WIDTH    (2)
  ) u_bus_sync (
    .clk_in   (mclk_in),
    .async_in ({link.scl, link.sda}),
    .sync_out (bus_s)
  );

  // Data edge while clock high marks frame limits
  always_comb begin
    scl_d_next    = bus_s[1];
    sda_d_next    = bus_s[0];
    link_rst_next = link_rst_reg;
    frame_next    = frame_reg;
    start_det     = bus_s[1] && scl_d_reg && sda_d_reg && !bus_s[0]; // RQ5
    stop_det      = bus_s[1] && scl_d_reg && !sda_d_reg && bus_s[0]; // RQ6
    if (start_det || stop_det) begin
      // Serial engine held idle; stop keeps it there until next start
      link_rst_next = 1'b1; // RQ11
      frame_next    = start_det;
    end else if (!bus_s[1]) begin
      // Release only while the clock is low, well before a rise
      link_rst_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      link_rst_reg <= 1'b1;
      frame_reg    <= 1'b0;
    end else begin
      scl_d_reg    <= scl_d_next;
      sda_d_reg    <= sda_d_next;
      link_rst_reg <= link_rst_next;
      frame_reg    <= frame_next;
    end
  end

  assign frame_active_out = frame_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: byte engine on the serial clock

  nvram_link_pkg::link_state_type state_reg;
  nvram_link_pkg::link_state_type state_next;

  logic [3:0]                        cnt_reg;
  logic [3:0]                        cnt_next;
  logic [7:0]                        shift_reg;
  logic [7:0]                        shift_next;
  logic [7:0]                        byte_in;
  logic [2:0]                        upper_reg;
  logic [2:0]                        upper_next;
  logic                              ack_ok_reg;
  logic                              ack_ok_next;
  logic [nvram_link_pkg::ADDR_W-1:0] addr_reg;
  logic [nvram_link_pkg::ADDR_W-1:0] addr_next;
  logic                              mem_we;
  logic                              wp_s;
  logic [7:0]                        rd_byte;
  logic                              drive_reg;
  logic                              drive_next;
  logic [7:0]                        mem [MEM_DEPTH]; // RQ16

  // Write protect is a pin; retimed to the serial clock
  bit_sync #(
    .WIDTH    (1)
  ) u_wp_sync (
    .clk_in   (link.scl),
    .async_in (link.wp),
    .sync_out (wp_s)
  );

  assign byte_in = {shift_reg[6:0], link.sda};
  assign rd_byte = mem[addr_reg]; // RQ15

  // Next state at each rising clock edge
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    upper_next  = upper_reg;
    ack_ok_next = ack_ok_reg;
    addr_next   = addr_reg;
    mem_we      = 1'b0;
    if (state_reg != nvram_link_pkg::LS_IDLE) begin
      if (cnt_reg != nvram_link_pkg::ACK_SLOT) begin
        // Data bit slots
        cnt_next = cnt_reg + 4'h1; // RQ8
        if (state_reg != nvram_link_pkg::LS_RDDATA) begin
          shift_next = byte_in; // RQ2
        end
        if (cnt_reg == nvram_link_pkg::LAST_DATA_SLOT) begin
          case (state_reg)
            nvram_link_pkg::LS_DEVADDR: begin
              ack_ok_next = byte_in[nvram_link_pkg::TYPE_MSB:nvram_link_pkg::TYPE_LSB] == TYPE_CODE; // RQ20
              upper_next  = byte_in[nvram_link_pkg::UPPER_MSB:nvram_link_pkg::UPPER_LSB];
              if (ack_ok_next && byte_in[nvram_link_pkg::RW_BIT]) begin
                addr_next = {upper_next, addr_reg[nvram_link_pkg::LOWER_MSB:0]}; // RQ19
              end
            end
            nvram_link_pkg::LS_LOWADDR: begin
              ack_ok_next = 1'b1;
              addr_next   = {upper_reg, byte_in}; // RQ18
            end
            nvram_link_pkg::LS_WRDATA: begin
              ack_ok_next = 1'b1;
            end
            default: begin
              ack_ok_next = 1'b0;
            end
          endcase
        end
      end else begin
        // Acknowledge slot, ninth rising edge
        cnt_next    = 4'h0;
        ack_ok_next = 1'b0;
        case (state_reg)
          nvram_link_pkg::LS_DEVADDR: begin
            if (!ack_ok_reg) begin
              state_next = nvram_link_pkg::LS_IDLE; // RQ21
            end else if (shift_reg[nvram_link_pkg::RW_BIT]) begin
              state_next = nvram_link_pkg::LS_RDDATA;
            end else begin
              state_next = nvram_link_pkg::LS_LOWADDR;
            end
          end
          nvram_link_pkg::LS_LOWADDR: begin
            state_next = nvram_link_pkg::LS_WRDATA;
          end
          nvram_link_pkg::LS_WRDATA: begin
            mem_we    = !wp_s; // RQ14 RQ24 RQ7
            addr_next = addr_reg + nvram_link_pkg::ADDR_STEP; // RQ22
          end
          nvram_link_pkg::LS_RDDATA: begin
            addr_next = addr_reg + nvram_link_pkg::ADDR_STEP; // RQ22
            if (link.sda) begin
              state_next = nvram_link_pkg::LS_IDLE; // RQ12
            end
          end
          default: begin
            state_next = nvram_link_pkg::LS_IDLE;
          end
        endcase
      end
    end
  end

  // Control state, cleared by every start and stop
  always_ff @(posedge link.scl or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      state_reg  <= nvram_link_pkg::LS_DEVADDR;
      cnt_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      upper_reg  <= 3'h0;
      ack_ok_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      upper_reg  <= upper_next;
      ack_ok_reg <= ack_ok_next;
    end
  end

  // Address buffer and array survive across frames
  always_ff @(posedge link.scl) begin
    addr_reg <= addr_next; // RQ17
    if (mem_we) begin
      mem[addr_reg] <= shift_reg;
    end
  end

  // Output bit chosen for the slot after the falling edge
  always_comb begin
    drive_next = 1'b0; // RQ10 RQ12
    if (state_reg == nvram_link_pkg::LS_RDDATA && cnt_reg != nvram_link_pkg::ACK_SLOT) begin
      drive_next = !rd_byte[~cnt_reg[2:0]];
    end else if (cnt_reg == nvram_link_pkg::ACK_SLOT && ack_ok_reg) begin
      drive_next = 1'b1; // RQ9
    end
  end

  // Data changes only on the falling edge
  always_ff @(negedge link.scl or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next; // RQ2
    end
  end

  // Pull low or release, never drive high; clock is input only
  assign link.s_sda_oe = drive_reg; // RQ3 RQ1

endmodule : nvram_slave_end

// ==== nvram_master_end.sv ====
// Master end: divides the system clock into the serial clock and runs byte commands
module nvram_master_end #(
  parameter int QTR_CYCLES = nvram_link_pkg::QTR_CYCLES
) (
  // System clock and reset
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  // Two-wire link
  nvram_link_if.master    link,
  // Command port
  input  wire logic       cmd_valid_in,
  input  wire logic [1:0] cmd_op_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       cmd_mack_in,
  input  wire logic       wp_in,
  output logic            cmd_ready_out,
  // Answer port
  output logic            rsp_valid_out,
  output logic [7:0]      rsp_data_out,
  output logic            rsp_nack_out
);

  nvram_link_pkg::host_state_type state_reg;
  nvram_link_pkg::host_state_type state_next;

  logic [15:0] tick_reg;
  logic [15:0] tick_next;
  logic [1:0]  qtr_reg;
  logic [1:0]  qtr_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic        scl_reg;
  logic        scl_next;
  logic        oe_reg;
  logic        oe_next;
  logic        wp_reg;
  logic        wp_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic        read_reg;
  logic        read_next;
  logic        mack_reg;
  logic        mack_next;
  logic        busy_reg;
  logic        busy_next;
  logic        ready_reg;
  logic        ready_next;
  logic        rv_reg;
  logic        rv_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        rnack_reg;
  logic        rnack_next;
  logic        sda_s;
  logic        qedge;

  bit_sync #(
    .WIDTH    (1)
  ) u_sda_sync (
    .clk_in   (mclk_in),
    .async_in (link.sda),
    .sync_out (sda_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Quarter-period sequencer

  always_comb begin
    state_next = state_reg;
    tick_next  = tick_reg;
    qtr_next   = qtr_reg;
    bit_next   = bit_reg;
    scl_next   = scl_reg;
    oe_next    = oe_reg;
    wp_next    = wp_reg;
    shift_next = shift_reg;
    read_next  = read_reg;
    mack_next  = mack_reg;
    busy_next  = busy_reg;
    ready_next = ready_reg;
    rv_next    = 1'b0;
    rdata_next = rdata_reg;
    rnack_next = rnack_reg;
    qedge      = tick_reg == 16'(QTR_CYCLES - 1);
    if (state_reg == nvram_link_pkg::HS_IDLE) begin
      ready_next = 1'b1;
      tick_next  = 16'h0000;
      qtr_next   = 2'h0;
      bit_next   = 4'h0;
      if (cmd_valid_in && ready_reg) begin
        ready_next = 1'b0;
        shift_next = cmd_data_in;
        read_next  = cmd_op_in == nvram_link_pkg::CMD_READ;
        mack_next  = cmd_mack_in;
        case (cmd_op_in)
          nvram_link_pkg::CMD_START: begin
            state_next = nvram_link_pkg::HS_START;
            if (!busy_reg) begin
              wp_next = wp_in; // RQ23
            end
          end
          default: begin
            // Stop and transfers only inside a frame
            if (busy_reg) begin
              state_next = (cmd_op_in == nvram_link_pkg::CMD_STOP) ? nvram_link_pkg::HS_STOP
                                                                   : nvram_link_pkg::HS_XFER;
            end
          end
        endcase
      end
    end else begin
      tick_next = qedge ? 16'h0000 : tick_reg + 16'h0001;
      if (qedge) begin
        qtr_next = qtr_reg + 2'h1;
        case (state_reg)
          nvram_link_pkg::HS_START: begin
            case (qtr_reg)
              2'h0: oe_next = 1'b0;
              2'h1: scl_next = 1'b1;
              2'h2: oe_next = 1'b1; // RQ5
              default: begin
                scl_next   = 1'b0;
                busy_next  = 1'b1;
                state_next = nvram_link_pkg::HS_IDLE;
              end
            endcase
          end
          nvram_link_pkg::HS_STOP: begin
            case (qtr_reg)
              2'h0: oe_next = 1'b1;
              2'h1: scl_next = 1'b1;
              2'h2: oe_next = 1'b0; // RQ13
              default: begin
                busy_next  = 1'b0;
                state_next = nvram_link_pkg::HS_IDLE;
              end
            endcase
          end
          default: begin
            case (qtr_reg)
              2'h0: begin
                // Data set while the clock is low
                if (bit_reg == nvram_link_pkg::ACK_SLOT) begin
                  oe_next = read_reg && mack_reg; // RQ9 RQ10
                end else begin
                  oe_next = !read_reg && !shift_reg[7]; // RQ4 RQ8
                end
              end
              2'h1: scl_next = 1'b1;
              2'h2: begin
                if (bit_reg == nvram_link_pkg::ACK_SLOT) begin
                  rnack_next = sda_s;
                end else begin
                  shift_next = {shift_reg[6:0], sda_s};
                end
              end
              default: begin
                scl_next = 1'b0;
                if (bit_reg == nvram_link_pkg::ACK_SLOT) begin
                  rv_next    = 1'b1;
                  rdata_next = shift_reg;
                  state_next = nvram_link_pkg::HS_IDLE;
                end else begin
                  bit_next = bit_reg + 4'h1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_reg <= nvram_link_pkg::HS_IDLE;
      tick_reg  <= 16'h0000;
      qtr_reg   <= 2'h0;
      bit_reg   <= 4'h0;
      scl_reg   <= 1'b1;
      oe_reg    <= 1'b0;
      wp_reg    <= 1'b0;
      shift_reg <= 8'h00;
      read_reg  <= 1'b0;
      mack_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      ready_reg <= 1'b0;
      rv_reg    <= 1'b0;
      rdata_reg <= 8'h00;
      rnack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tick_reg  <= tick_next;
      qtr_reg   <= qtr_next;
      bit_reg   <= bit_next;
      scl_reg   <= scl_next;
      oe_reg    <= oe_next;
      wp_reg    <= wp_next;
      shift_reg <= shift_next;
      read_reg  <= read_next;
      mack_reg  <= mack_next;
      busy_reg  <= busy_next;
      ready_reg <= ready_next;
      rv_reg    <= rv_next;
      rdata_reg <= rdata_next;
      rnack_reg <= rnack_next;
    end
  end

  // Outputs straight from flops
  assign link.scl      = scl_reg;
  assign link.m_sda_oe = oe_reg;
  assign link.wp       = wp_reg;
  assign cmd_ready_out = ready_reg;
  assign rsp_valid_out = rv_reg;
  assign rsp_data_out  = rdata_reg;
  assign rsp_nack_out  = rnack_reg;

endmodule : nvram_master_end

// ==== nvram_link_asserts.sv ====
// Protocol checks on the two-wire link between the master end and the slave end
module nvram_link_asserts (
  // System clock and reset
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  // Link wires
  input  wire logic scl,
  input  wire logic m_sda_oe,
  input  wire logic s_sda_oe,
  input  wire logic wp,
  input  wire logic sda,
  // Slave status
  input  wire logic frame_active_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       scl_d_reg;
  logic       scl_d_next;
  logic       sda_d_reg;
  logic       sda_d_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       start_ev;
  logic       stop_ev;
  logic       scl_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // Edge and condition detection
  assign scl_rise = scl && !scl_d_reg;
  assign start_ev = scl && scl_d_reg && sda_d_reg && !sda;
  assign stop_ev  = scl && scl_d_reg && !sda_d_reg && sda;

  // Bit slot count, 9 is the acknowledge slot
  always_comb begin
    scl_d_next = scl;
    sda_d_next = sda;
    cnt_next   = cnt_reg;
    if (start_ev) begin
      cnt_next = 4'h0;
    end else if (scl_rise) begin
      cnt_next = (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
    end
  end

  // Registers only
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      cnt_reg   <= 4'h0;
    end else begin
      scl_d_reg <= scl_d_next;
      sda_d_reg <= sda_d_next;
      cnt_reg   <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  a_change_on_fall: assert property ($changed(s_sda_oe) |-> $fell(scl))
    else $error("slave data changed away from a clock fall");
  a_start_opens: assert property (start_ev |-> ##[1:6] frame_active_out)
    else $error("start not seen by slave");
  a_stop_closes: assert property (stop_ev |-> ##[1:6] !frame_active_out)
    else $error("stop did not return slave to standby");
  a_standby_quiet: assert property (!frame_active_out |-> !s_sda_oe)
    else $error("slave drives data outside a frame");
  a_nack_release: assert property ((scl_rise && cnt_reg == 4'h8 && sda) |-> !s_sda_oe [*8])
    else $error("slave drove data after a not-acknowledge");
  a_drive_stands: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
    else $error("slave low drive too short");
  a_one_driver_ninth: assert property ((scl_rise && cnt_reg == 4'h8) |-> !(m_sda_oe && s_sda_oe))
    else $error("both ends drive in acknowledge slot");
  a_wp_steady: assert property ((frame_active_out && $past(frame_active_out)) |-> $stable(wp))
    else $error("write protect changed inside a frame");
  a_stop_bus_free: assert property ($fell(frame_active_out) |-> (scl && sda))
    else $error("bus not free after stop");

  // Main scenarios reached
  c_start: cover property (start_ev);
  c_nack: cover property (scl_rise && cnt_reg == 4'h8 && sda);
  c_slave_drive: cover property ($rose(s_sda_oe));
endmodule : nvram_link_asserts

// ==== i2c_nvram_slave_port_tb.sv ====
// Self-checking bench joining the master end and the memory slave end
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module i2c_nvram_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] TC = nvram_link_pkg::TYPE_CODE_DEFAULT; // Arbitrary value
  logic       mclk_in;
  logic       sys_rst_in;
  logic       cmd_valid;
  logic [1:0] op;
  logic [7:0] din;
  logic       mack;
  logic       wp_drv;
  logic       ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic       frame_active;
  logic [7:0] got;
  logic       got_nack;
  int         n_errors;
  int         n_compared;

  nvram_link_if link_if();

  nvram_master_end #(.QTR_CYCLES(3)) nvram_master_end_i (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link_if.master),
    .cmd_valid_in(cmd_valid), .cmd_op_in(op), .cmd_data_in(din), .cmd_mack_in(mack),
    .wp_in(wp_drv), .cmd_ready_out(ready), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack));

  nvram_slave_end nvram_slave_end_i (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link_if.slave),
    .frame_active_out(frame_active));

  nvram_link_asserts nvram_link_asserts_i (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .scl(link_if.scl),
    .m_sda_oe(link_if.m_sda_oe), .s_sda_oe(link_if.s_sda_oe), .wp(link_if.wp),
    .sda(link_if.sda), .frame_active_out(frame_active));

  // System clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // Bounded wait for command port idle, capturing any answer
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(negedge mclk_in);
      if (rsp_valid === 1'b1) begin
        got      = rsp_data;
        got_nack = rsp_nack;
      end
      i++;
    end while (ready !== 1'b1 && i < 2000);
    if (i >= 2000) begin
      n_errors++;
      $display("ERROR cmd_ready expected 1 seen %b", ready);
      test_done();
    end
  endtask : wait_ready

  // One command on the master's command port
  task automatic cmd(input logic [1:0] o, input logic [7:0] d, input logic m);
    got       = 8'hXX;
    got_nack  = 1'bx;
    cmd_valid = 1'b1;
    op        = o;
    din       = d;
    mack      = m;
    @(negedge mclk_in);
    cmd_valid = 1'b0;
    wait_ready();
  endtask : cmd

  task automatic st();
    cmd(nvram_link_pkg::CMD_START, 8'h00, 1'b0);
  endtask : st

  task automatic sp();
    cmd(nvram_link_pkg::CMD_STOP, 8'h00, 1'b0);
  endtask : sp

  // Byte out: bus echo and acknowledge level
  task automatic wr(input logic [7:0] d, input logic en);
    cmd(nvram_link_pkg::CMD_WRITE, d, 1'b0);
    `CHK("echo", d, got)
    `CHK("nack", en, got_nack)
  endtask : wr

  // Byte in with master acknowledge choice
  task automatic rd(input logic m, input logic [7:0] e);
    cmd(nvram_link_pkg::CMD_READ, 8'h00, m);
    `CHK("rdata", e, got)
    `CHK("mack", ~m, got_nack)
  endtask : rd

  function automatic logic [7:0] dw(input logic [2:0] up, input logic rw);
    return {TC, up, rw};
  endfunction : dw

  // Main sequence
  initial begin
    n_errors = 0;
    n_compared = 0;
    sys_rst_in = 1'b1;
    {cmd_valid, op, din, mack, wp_drv} = '0;
    repeat (2) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    wait_ready();
    // Stop with no frame open is dropped
    sp();
    `CHK("frame", 1'b0, frame_active)
    // Page write across the top of the array
    st();
    `CHK("frame", 1'b1, frame_active)
    wr(dw(3'h7, 1'b0), 1'b0);
    wr(8'hFF, 1'b0);
    wr(8'hA1, 1'b0);
    wr(8'hA2, 1'b0);
    sp();
    `CHK("frame", 1'b0, frame_active)
    // Random read then sequential read through the wrap
    st(); wr(dw(3'h7, 1'b0), 1'b0); wr(8'hFF, 1'b0); st(); wr(dw(3'h7, 1'b1), 1'b0);
    rd(1'b1, 8'hA1);
    rd(1'b0, 8'hA2);
    sp();
    // Two bytes at 0x210, then a protected overwrite
    st(); wr(dw(3'h2, 1'b0), 1'b0); wr(8'h10, 1'b0); wr(8'h33, 1'b0); wr(8'h44, 1'b0); sp();
    wp_drv = 1'b1;
    st(); wr(dw(3'h2, 1'b0), 1'b0); wr(8'h10, 1'b0); wr(8'h55, 1'b0); wr(8'h66, 1'b0); sp();
    // Read back with protect still high
    st(); wr(dw(3'h2, 1'b0), 1'b0); wr(8'h10, 1'b0); st(); wr(dw(3'h2, 1'b1), 1'b0);
    rd(1'b0, 8'h33);
    sp();
    wp_drv = 1'b0;
    // Current address read continues from the buffer
    st(); wr(dw(3'h2, 1'b1), 1'b0);
    rd(1'b0, 8'h44);
    sp();
    // Foreign type code is never acknowledged
    st();
    wr({~TC, 3'h2, 1'b0}, 1'b1);
    wr(8'h10, 1'b1);
    sp();
    // Stop right after the address byte, before any data byte, writes nothing
    st(); wr(dw(3'h2, 1'b0), 1'b0); wr(8'h10, 1'b0); sp();
    `CHK("frame", 1'b0, frame_active)
    st(); wr(dw(3'h2, 1'b1), 1'b0);
    rd(1'b0, 8'h33);
    sp();
    test_done();
  end
endmodule : i2c_nvram_slave_port_tb
